// ===== logic/plcc_pkg.sv
package plcc_pkg;
    // Register byte offsets
    localparam logic [7:0] LINK_CAP_OFS = 8'h74;
    localparam logic [7:0] LINK_CTRL_OFS = 8'h78;
    // Capability fields and values
    localparam int CAP_SPEED_LSB = 0;
    localparam int CAP_WIDTH_LSB = 4;
    localparam int CAP_ASPM_LSB = 10;
    localparam int CAP_L0S_LAT_LSB = 12;
    localparam int CAP_L1_LAT_LSB = 15;
    localparam int CAP_PORT_LSB = 24;
    localparam logic [3:0] SPEED_2G5 = 4'h1;
    localparam logic [5:0] WIDTH_X4 = 6'h04;
    localparam logic [1:0] ASPM_BOTH = 2'h3;
    localparam logic [2:0] L0S_LAT_1US_2US = 3'h5;
    localparam logic [2:0] L1_LAT_16US_32US = 3'h5;
    localparam logic [7:0] PORT_NUM = 8'h00;
    // Control fields
    localparam int CTL_ASPM_LSB = 0;
    localparam int CTL_RCB_BIT = 3;
    localparam int CTL_DIS_BIT = 4;
    localparam int CTL_RETRAIN_BIT = 5;
    localparam int CTL_CCLK_BIT = 6;
    localparam int CTL_XSYNC_BIT = 7;
    localparam logic [1:0] ASPM_CTL_RST = 2'h0;
    localparam logic [1:0] ASPM_L0S = 2'h1;
    localparam logic [1:0] ASPM_L1 = 2'h2;
    // Extended sync ordered-set counts
    localparam int FTS_XSYNC = 4096;
    localparam int TS1_XSYNC = 1024;
    localparam logic [12:0] FTS_CNT_LAST = 13'(FTS_XSYNC - 1);
    localparam logic [12:0] TS1_CNT_LAST = 13'(TS1_XSYNC - 1);
    localparam logic [12:0] CNT_ZERO = 13'h0000;
    // Sequencer states
    typedef enum logic [4:0] {
        SEQ_IDLE = 5'b00001,
        SEQ_FTS = 5'b00010,
        SEQ_SKIP = 5'b00100,
        SEQ_TS1 = 5'b01000,
        SEQ_DONE = 5'b10000
    } plcc_seq_t;
endpackage

// ===== logic/plcc_regs.sv
// Overview of operation
// - Max speed field reads 2.5 Gbps code
// - Max width reads x4, not loadable
// - ASPM support field, default both
// - L0s exit latency code 101b
// - L1 exit latency 101b, loadable
// - Port number reads zero
// - ASPM control RW, default 00b
// - Completion boundary bit: 64 or 128
// - Reverse mode link disable bit RW
// - Reverse mode retrain pulses, reads zero
// - Forward mode disable/retrain read zero
// - Common clock bit RW, default 0
// - Extended sync sends 4096 FTS
// - Then exactly one SKIP set
// - Extended sync sends 1024 TS1 in Recovery
// - Receiver L0s entry always allowed
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module plcc_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Strap and EEPROM default loading
    input wire logic reverse_mode,
    input wire logic ee_load,
    input wire logic [1:0] ee_aspm_sup,
    input wire logic [2:0] ee_l1_lat,
    input wire logic [7:0] ee_ctrl,
    // Link training and power management
    output logic [1:0] aspm_en,
    output logic rx_l0s_allow,
    output logic rcb_128,
    output logic link_disable,
    output logic retrain_pulse,
    output logic common_clk,
    // Ordered-set requests for L0s exit and Recovery
    input wire logic l0s_exit_req,
    input wire logic recovery_req,
    input wire logic os_ready,
    output logic fts_tx,
    output logic skip_tx,
    output logic ts1_tx,
    output logic os_busy
);
    // Strap and EEPROM inputs come from pins: two flops first
    logic [14:0] pin_s1_q, pin_s2_q;
    logic rev_q, ld_q;
    logic [1:0] aspm_sup_q;
    logic [2:0] l1_lat_q;
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic ack_q;
    logic [31:0] rdat_q;
    logic retrain_q;
    plcc_pkg::plcc_seq_t st_q, st_d;
    logic [12:0] cnt_q, cnt_d;
    logic fts_q, skip_q, ts1_q, busy_q;

    always_ff @(posedge ref_clk) begin
        pin_s1_q <= {reverse_mode, ee_load, ee_aspm_sup, ee_l1_lat, ee_ctrl};
        pin_s2_q <= pin_s1_q;
    end
    wire logic s_rev = pin_s2_q[14];
    wire logic s_load = pin_s2_q[13];
    wire logic [1:0] s_aspm = pin_s2_q[12:11];
    wire logic [2:0] s_l1 = pin_s2_q[10:8];
    wire logic [7:0] s_ctl = pin_s2_q[7:0];

    // Bus decode
    wire logic req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire logic hit_cap = (wb_adr_i == plcc_pkg::LINK_CAP_OFS);
    wire logic hit_ctl = (wb_adr_i == plcc_pkg::LINK_CTRL_OFS);
    wire logic wr_ctl = req & wb_we_i & hit_ctl & wb_sel_i[0];

    wire logic [31:0] cap_word = {plcc_pkg::PORT_NUM, 6'h00, l1_lat_q,
        plcc_pkg::L0S_LAT_1US_2US, aspm_sup_q, plcc_pkg::WIDTH_X4, plcc_pkg::SPEED_2G5};
    // Retrain always reads zero; status half of the word is outside this block
    wire logic [31:0] ctl_word = {24'h00_0000, ctl_q[7:6], 1'b0, ctl_q[4:3], 1'b0, ctl_q[1:0]};
    wire logic [31:0] rd_mux = hit_cap ? cap_word : (hit_ctl ? ctl_word : 32'h0000_0000);

    // Writes only touch lane 0; reserved bits 2 and 15:8 are dropped
    always_comb begin
        ctl_d = ctl_q;
        if (wr_ctl) begin
            ctl_d[1:0] = wb_dat_i[1:0];
            ctl_d[3] = wb_dat_i[plcc_pkg::CTL_RCB_BIT];
            ctl_d[4] = rev_q & wb_dat_i[plcc_pkg::CTL_DIS_BIT];
            ctl_d[6] = wb_dat_i[plcc_pkg::CTL_CCLK_BIT];
            ctl_d[7] = wb_dat_i[plcc_pkg::CTL_XSYNC_BIT];
        end
        if (!rev_q) begin
            ctl_d[4] = 1'b0;
        end
        ctl_d[2] = 1'b0;
        ctl_d[5] = 1'b0;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            retrain_q <= 1'b0;
        end else begin
            ack_q <= req;
            rdat_q <= req ? rd_mux : 32'h0000_0000;
            retrain_q <= wr_ctl & rev_q & wb_dat_i[plcc_pkg::CTL_RETRAIN_BIT];
        end
    end

    // Defaults; EEPROM load overrides loadable fields only
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rev_q <= 1'b0;
            ld_q <= 1'b0;
            aspm_sup_q <= plcc_pkg::ASPM_BOTH;
            l1_lat_q <= plcc_pkg::L1_LAT_16US_32US;
            ctl_q <= 8'h00;
        end else begin
            rev_q <= s_rev;
            ld_q <= s_load;
            if (s_load & ~ld_q) begin
                aspm_sup_q <= s_aspm;
                l1_lat_q <= s_l1;
                ctl_q <= {s_ctl[7:6], 1'b0, s_rev & s_ctl[4], s_ctl[3], 1'b0, s_ctl[1:0]};
            end else begin
                ctl_q <= ctl_d;
            end
        end
    end

    // Ordered-set sequencer; one set per os_ready handshake
    wire logic xsync = ctl_q[plcc_pkg::CTL_XSYNC_BIT];
    wire logic cnt_end_fts = (cnt_q == plcc_pkg::FTS_CNT_LAST);
    wire logic cnt_end_ts1 = (cnt_q == plcc_pkg::TS1_CNT_LAST);
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
            plcc_pkg::SEQ_IDLE: begin
                cnt_d = plcc_pkg::CNT_ZERO;
                if (xsync & recovery_req) begin
                    st_d = plcc_pkg::SEQ_TS1;
                end else if (xsync & l0s_exit_req) begin
                    st_d = plcc_pkg::SEQ_FTS;
                end
            end
            plcc_pkg::SEQ_FTS: begin
                if (os_ready) begin
                    cnt_d = cnt_q + 13'h0001;
                    if (cnt_end_fts) begin
                        st_d = plcc_pkg::SEQ_SKIP;
                    end
                end
            end
            plcc_pkg::SEQ_SKIP: begin
                if (os_ready) begin
                    st_d = plcc_pkg::SEQ_DONE;
                end
            end
            plcc_pkg::SEQ_TS1: begin
                if (os_ready) begin
                    cnt_d = cnt_q + 13'h0001;
                    if (cnt_end_ts1) begin
                        st_d = plcc_pkg::SEQ_DONE;
                    end
                end
            end
            plcc_pkg::SEQ_DONE: begin
                st_d = plcc_pkg::SEQ_IDLE;
            end
            default: begin
                st_d = plcc_pkg::SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= plcc_pkg::SEQ_IDLE;
            cnt_q <= 13'h0000;
            fts_q <= 1'b0;
            skip_q <= 1'b0;
            ts1_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            fts_q <= (st_d == plcc_pkg::SEQ_FTS);
            skip_q <= (st_d == plcc_pkg::SEQ_SKIP);
            ts1_q <= (st_d == plcc_pkg::SEQ_TS1);
            busy_q <= (st_d != plcc_pkg::SEQ_IDLE);
        end
    end

    // Outputs straight from flops, except rx_l0s_allow tied high
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign aspm_en = ctl_q[1:0];
    // Receiver may always enter L0s, whatever the control field says
    assign rx_l0s_allow = 1'b1;
    assign rcb_128 = ctl_q[plcc_pkg::CTL_RCB_BIT];
    assign link_disable = ctl_q[plcc_pkg::CTL_DIS_BIT];
    assign retrain_pulse = retrain_q;
    assign common_clk = ctl_q[plcc_pkg::CTL_CCLK_BIT];
    assign fts_tx = fts_q;
    assign skip_tx = skip_q;
    assign ts1_tx = ts1_q;
    assign os_busy = busy_q;
endmodule
`default_nettype wire

// ===== dv/plcc_regs_chk.sv
`timescale 1ns/1ns
`default_nettype none
module plcc_regs_chk (
    // Bus side
    input wire logic ref_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    // Link side
    input wire logic rx_l0s_allow, retrain_pulse, fts_tx, skip_tx, os_ready
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire rd = wb_ack_o && !wb_we_i;
    wire cap = wb_adr_i == 8'h74;
    wire ctl = wb_adr_i == 8'h78;
    a_ack_due: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    // Loadable fields masked out
    a_cap_fixed: assert property (rd && cap |-> (wb_dat_o & 32'hfffc_73ff) == 32'h0000_5041)
        else $error("cap field");
    a_ctl_resv: assert property (rd && ctl |-> wb_dat_o[31:8] == 0 && !wb_dat_o[5] && !wb_dat_o[2])
        else $error("ctl reserved");
    a_unmapped: assert property (rd && !cap && !ctl |-> wb_dat_o == 0) else $error("unmapped");
    a_rx_l0s: assert property (rx_l0s_allow) else $error("rx l0s");
    a_rtr_pulse: assert property (retrain_pulse |=> !retrain_pulse) else $error("retrain");
    a_fts_skip: assert property ($fell(fts_tx) |-> skip_tx) else $error("no skip");
    a_skip_once: assert property (skip_tx && os_ready |=> !skip_tx && !fts_tx) else $error("skip twice");
    c_write: cover property (wb_ack_o && wb_we_i);
    c_retrain: cover property (retrain_pulse);
    c_skip: cover property (skip_tx && os_ready);
endmodule
bind plcc_regs plcc_regs_chk u_chk (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .wb_adr_i,
    .wb_dat_o, .rx_l0s_allow, .retrain_pulse, .fts_tx, .skip_tx, .os_ready);
`default_nettype wire

// ===== dv/plcc_link_model.sv
`timescale 1ns/1ns
`default_nettype none
module plcc_link_model (
    // Clock, reset, pacing
    input wire logic ref_clk, rst, slow,
    // Sets offered and taken
    input wire logic fts_tx, skip_tx, ts1_tx,
    output logic os_ready,
    output logic [15:0] n_fts, n_skip, n_ts1
);
    // Random stalls stretch a sequence to test holding
    always_ff @(posedge ref_clk) begin
        os_ready <= !slow || $urandom_range(1, 0) == 1;
        if (rst) begin
            {n_fts, n_skip, n_ts1} <= '0;
        end else if (os_ready) begin
            n_fts <= n_fts + 16'(fts_tx);
            n_skip <= n_skip + 16'(skip_tx);
            n_ts1 <= n_ts1 + 16'(ts1_tx);
        end
    end
endmodule
`default_nettype wire

// ===== dv/pcie_link_cap_ctrl_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module pcie_link_cap_ctrl_regs_tb_top;
    logic ref_clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, reverse_mode = 0, ee_load = 0;
    logic l0s_exit_req = 0, recovery_req = 0, slow = 0, wb_ack_o, rx_l0s_allow, rcb_128, link_disable;
    logic retrain_pulse, common_clk, os_ready, fts_tx, skip_tx, ts1_tx, os_busy;
    logic [1:0] aspm_en, ee_aspm = 2'h3;
    logic [2:0] ee_l1 = 3'h5;
    logic [7:0] ee_ctl = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [7:0] wb_adr_i = 8'h00;
    logic [15:0] n_fts, n_skip, n_ts1;
    logic [31:0] wb_dat_i = '0, wb_dat_o, r, d;
    int num_errors = 0, checks_done = 0, cycles = 0, rtr = 0;
    plcc_regs u_plcc_regs (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .reverse_mode, .ee_load, .ee_aspm_sup(ee_aspm), .ee_l1_lat(ee_l1), .ee_ctrl(ee_ctl),
        .aspm_en, .rx_l0s_allow, .rcb_128, .link_disable, .retrain_pulse, .common_clk, .l0s_exit_req,
        .recovery_req, .os_ready, .fts_tx, .skip_tx, .ts1_tx, .os_busy);
    plcc_link_model u_plcc_link_model (.ref_clk, .rst, .slow, .fts_tx, .skip_tx, .ts1_tx, .os_ready,
        .n_fts, .n_skip, .n_ts1);
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic summarize();
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        rtr += 32'(retrain_pulse === 1'b1);
        if (cycles == 40000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] ctl_exp(input logic [31:0] v, input logic rev);
        return v & (rev ? 32'h0000_00db : 32'h0000_00cb);
    endfunction
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, v, s};
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic seq(input logic rec, s, input logic [31:0] f, k, t);
        slow <= s;
        @(posedge ref_clk);
        {recovery_req, l0s_exit_req} <= {rec, !rec};
        @(posedge ref_clk);
        {recovery_req, l0s_exit_req} <= 2'b00;
        do @(posedge ref_clk); while (os_busy !== 1'b0);
        repeat (2) @(posedge ref_clk);
        chk(32'(n_fts), f);
        chk(32'(n_skip), k);
        chk(32'(n_ts1), t);
    endtask
    initial begin
        void'($urandom(32'h0b4c_0a38));
        repeat (12) @(posedge ref_clk);
        rst <= 0;
        wb(1, 8'h74, '1, 4'hf);
        wb(0, 8'h74, '0, 4'hf);
        chk(r, 32'h0002_dc41);
        for (int i = 0; i < 12; i++) begin
            d = (i < 4) ? 32'(i) : $urandom;
            wb(1, 8'h78, d, 4'h1);
            wb(0, 8'h78, '0, 4'hf);
            chk(r, ctl_exp(d, 0));
            chk(32'({aspm_en, rcb_128, link_disable, common_clk}), 32'({d[1:0], d[3], 1'b0, d[6]}));
        end
        wb(1, 8'h78, '1, 4'he);
        wb(0, 8'h7c, '0, 4'hf);
        chk(r, '0);
        wb(0, 8'h78, '0, 4'hf);
        chk(r, ctl_exp(d, 0));
        reverse_mode <= 1;
        repeat (5) @(posedge ref_clk);
        wb(1, 8'h78, 32'h0000_0031, 4'h1);
        wb(0, 8'h78, '0, 4'hf);
        chk(r, ctl_exp(32'h0000_0031, 1));
        chk(32'({link_disable, 8'(rtr)}), 32'h0000_0101);
        seq(0, 0, 0, 0, 0);
        wb(1, 8'h78, 32'h0000_0080, 4'h1);
        seq(0, 0, 4096, 1, 0);
        seq(1, 1, 4096, 1, 1024);
        // Load new defaults; width and L0s latency must not move
        {ee_aspm, ee_l1, ee_ctl} <= {2'h1, 3'h2, 8'hff};
        ee_load <= 1;
        repeat (5) @(posedge ref_clk);
        wb(0, 8'h74, '0, 4'hf);
        chk(r, 32'h0001_5441);
        wb(0, 8'h78, '0, 4'hf);
        chk(r, ctl_exp(32'h0000_00ff, 1));
        summarize();
    end
endmodule
`default_nettype wire
